// ---- rtl/valve_pkg.sv ----
// Shared constants, register map and carrier types for the valve position block
package valve_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_MS = 2000;
  localparam logic [19:0] MS_PER_S = 20'h0_03E8;
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_MV = 8'h01;
  localparam logic [7:0] IDX_POS_DB = 8'h02;
  localparam logic [7:0] IDX_HYST = 8'h03;
  localparam logic [7:0] IDX_PV_DB = 8'h04;
  localparam logic [7:0] IDX_TRAVEL = 8'h05;
  localparam logic [7:0] IDX_SHUT = 8'h06;
  localparam logic [7:0] IDX_OPEN = 8'h07;
  localparam logic [7:0] IDX_POT_RNG = 8'h08;
  localparam logic [7:0] IDX_MONITOR = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] IDX_CLEAR = 8'h0B;
  localparam logic [7:0] IDX_ENABLE = 8'h0C;
  localparam logic [7:0] IDX_DRIVE = 8'h0D;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_CAL_BIT = 1;
  localparam int MON_ERR_BIT = 15;
  localparam int EVT_CAL_DONE = 0;
  localparam int EVT_CAL_ERR = 1;
  localparam int EVT_MON_ERR = 2;
  localparam int NUM_EVT = 3;
  // ----------------------------------------------------------------
  // Limits and reset values, percentages in 0.1 % steps
  // ----------------------------------------------------------------
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  localparam logic [15:0] MON_MIN = 16'hFF9C;
  localparam logic [15:0] MON_MAX = 16'h044C;
  localparam logic [15:0] DB_MIN = 16'h0001;
  localparam logic [15:0] DB_MAX = 16'h0064;
  localparam logic [15:0] DB_RST_FEEDBACK = 16'h0028;
  localparam logic [15:0] DB_RST_ESTIMATE = 16'h0014;
  localparam logic [15:0] HYST_MIN = 16'h0001;
  localparam logic [15:0] HYST_MAX = 16'h00C8;
  localparam logic [15:0] HYST_RST = 16'h0008;
  localparam logic [15:0] PV_DB_MAX = 16'h270F;
  localparam logic [15:0] PV_DB_RST = 16'h0000;
  localparam logic [15:0] TRAVEL_MAX = 16'h03E7;
  localparam logic [15:0] TRAVEL_RST = 16'h001E;
  localparam logic [15:0] COUNT_MAX = 16'h270F;
  localparam logic [15:0] SHUT_RST = 16'h0000;
  localparam logic [15:0] OPEN_RST = 16'h270F;
  localparam logic [15:0] POT_RNG_MAX = 16'h0005;
  localparam logic [15:0] POT_RNG_STEP = 16'h0683;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef enum logic {
    OPEN_LOOP_ESTIMATE_MODE,
    FEEDBACK_LOOP_MODE
  } loop_mode_select_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [15:0] count;
  } pot_in_t;

  typedef struct packed {
    logic open_drv;
    logic close_drv;
  } drive_t;

  typedef struct packed {
    logic onoff_allowed;
    logic loop_break_alarm_allowed;
    logic heater_alarm_allowed;
    logic p_pd_allowed;
    logic at40_allowed;
  } feature_t;
endpackage

// ---- rtl/valve_position_ctrl.sv ----
// Position-proportional valve motor drive with calibration and opening monitor
//
// Overview of operation
// R1 - Mode selector: estimate or feedback; estimate after reset.
// R2 - Estimate mode drives the valve from travel time, no feedback.
// R3 - Disable on/off, loop break, heater alarms; estimate mode also P/PD, 40% tune.
// R4 - Calibration request opens fully, then closes fully, then clears itself.
// R5 - Calibration stores open count, shut count and pot range.
// R6 - Calibration measures full stroke time and writes travel time.
// R7 - Calibration error if pot constant, backwards, or invalid.
// R8 - Monitor reports -10.0..110.0 %, error if uncalibrated, no pot, pot fault.
// R9 - Both drives stop while demand minus opening is within position dead band.
// R10 - Position dead band 0.1..10.0 %, default 4.0 feedback, 2.0 estimate.
// R11 - Open/close hysteresis 0.1..20.0 offsets switch points, default 0.8.
// R12 - Process value dead band 0..9999 suppresses drive, default 0.0.
// R13 - Travel time 0..999 s, default 30.
// R14 - Shut and open counts 0..9999, defaults 0 and 9999.
// R15 - Estimate integrates open minus close time, scaled, clamped to stroke.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module valve_position_ctrl #(
  parameter int MS_CYCLES = valve_pkg::TICK_CYCLES
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  output logic irq, // Level interrupt
  input wire valve_pkg::pot_in_t pot, // Potentiometer sample from ADC
  input wire logic pot_present_pin, // Pot fitted sense pin
  input wire logic [15:0] process_value, // Measured process value
  input wire logic [15:0] set_point, // Target process value
  output valve_pkg::drive_t drive, // Motor open and close outputs
  output valve_pkg::feature_t features // Permitted control features
);
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_OPEN,
    CAL_CLOSE
  } cal_state_t;

  function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
    sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  valve_pkg::loop_mode_select_t mode_ff;
  cal_state_t cal_ff, nxt_cal;
  logic [15:0] mv_ff, pos_db_ff, hyst_ff, pv_db_ff, travel_ff, shut_ff, open_ff, pot_rng_ff;
  logic db_user_ff, calibrated_ff, cal_err_ff, mon_err_ff;
  logic [valve_pkg::NUM_EVT-1:0] sts_ff, ena_ff;
  logic [15:0] rdata_ff;
  valve_pkg::drive_t drv_ff;
  valve_pkg::feature_t feat_ff;
  logic [2:0] pres_sync_ff;
  logic pres_ff;

  wire [7:0] idx = {2'b00, addr[7:2]};
  wire wr_ctrl = wr && idx == valve_pkg::IDX_CTRL;
  wire wr_mv = wr && idx == valve_pkg::IDX_MV;
  wire wr_db = wr && idx == valve_pkg::IDX_POS_DB;
  wire wr_hyst = wr && idx == valve_pkg::IDX_HYST;
  wire wr_pvdb = wr && idx == valve_pkg::IDX_PV_DB;
  wire wr_travel = wr && idx == valve_pkg::IDX_TRAVEL;
  wire wr_shut = wr && idx == valve_pkg::IDX_SHUT;
  wire wr_open = wr && idx == valve_pkg::IDX_OPEN;
  wire wr_rng = wr && idx == valve_pkg::IDX_POT_RNG;
  wire wr_clr = wr && idx == valve_pkg::IDX_CLEAR;
  wire wr_ena = wr && idx == valve_pkg::IDX_ENABLE;
  wire cal_start = wr_ctrl && wdata[valve_pkg::CTRL_CAL_BIT] && cal_ff == CAL_IDLE;
  wire new_mode = wdata[valve_pkg::CTRL_MODE_BIT];

  // ----------------------------------------------------------------
  // Pot presence pin, three stages, change accepted when last two agree
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pres_sync_ff <= 3'h0;
      pres_ff <= 1'b0;
    end else begin
      pres_sync_ff <= {pres_sync_ff[1:0], pot_present_pin};
      if (pres_sync_ff[1] == pres_sync_ff[2]) begin
        pres_ff <= pres_sync_ff[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  wire tick = tick_cnt_ff == 32'(MS_CYCLES - 1);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  logic [15:0] last_pot_ff, cal_open_ff;
  logic [11:0] stall_ff;
  logic [19:0] stroke_ms_ff;
  wire pot_bad = pot.fault || !pot.valid || !pres_ff;
  wire pot_moved = pot.count != last_pot_ff;
  wire stalled = stall_ff == 12'(valve_pkg::STALL_MS);
  wire cal_abort = cal_ff != CAL_IDLE && pot_bad; // [R7]
  wire close_end = cal_ff == CAL_CLOSE && stalled && !pot_bad;
  wire dir_bad = close_end && cal_open_ff <= pot.count; // [R7]
  wire cal_ok = close_end && !dir_bad;
  wire cal_fail = cal_abort || dir_bad;
  wire [19:0] stroke_net = stroke_ms_ff - 20'(valve_pkg::STALL_MS);
  wire [19:0] stroke_s = stroke_net / valve_pkg::MS_PER_S;
  wire [15:0] span_cal = cal_open_ff - pot.count;
  wire [15:0] rng_cal = sat(span_cal / valve_pkg::POT_RNG_STEP, valve_pkg::ZERO16,
                            valve_pkg::POT_RNG_MAX);

  always_comb begin
    nxt_cal = cal_ff;
    case (cal_ff)
      CAL_IDLE: begin
        if (cal_start) begin
          nxt_cal = CAL_OPEN; // [R4]
        end
      end
      CAL_OPEN: begin
        if (cal_abort) begin
          nxt_cal = CAL_IDLE;
        end else if (stalled) begin
          nxt_cal = CAL_CLOSE; // [R4]
        end
      end
      CAL_CLOSE: begin
        if (cal_abort || close_end) begin
          nxt_cal = CAL_IDLE; // [R4]
        end
      end
      default: nxt_cal = CAL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cal_ff <= CAL_IDLE;
      last_pot_ff <= 16'h0000;
      stall_ff <= 12'h000;
      cal_open_ff <= 16'h0000;
      stroke_ms_ff <= 20'h0_0000;
    end else begin
      cal_ff <= nxt_cal;
      last_pot_ff <= pot.count;
      if (cal_ff != nxt_cal || pot_moved) begin
        stall_ff <= 12'h000; // Motor at an end once the pot stops moving
      end else if (tick && !stalled) begin
        stall_ff <= stall_ff + 12'h001;
      end
      if (cal_ff == CAL_OPEN && stalled) begin
        cal_open_ff <= pot.count;
      end
      if (cal_ff != CAL_CLOSE) begin
        stroke_ms_ff <= 20'h0_0000;
      end else if (tick) begin
        stroke_ms_ff <= stroke_ms_ff + 20'h0_0001; // [R6]
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= valve_pkg::OPEN_LOOP_ESTIMATE_MODE; // [R1]
      mv_ff <= 16'h0000;
      pos_db_ff <= valve_pkg::DB_RST_ESTIMATE; // [R10]
      db_user_ff <= 1'b0;
      hyst_ff <= valve_pkg::HYST_RST; // [R11]
      pv_db_ff <= valve_pkg::PV_DB_RST; // [R12]
      travel_ff <= valve_pkg::TRAVEL_RST; // [R13]
      shut_ff <= valve_pkg::SHUT_RST; // [R14]
      open_ff <= valve_pkg::OPEN_RST; // [R14]
      pot_rng_ff <= 16'h0000;
      calibrated_ff <= 1'b0;
      cal_err_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_ff <= valve_pkg::loop_mode_select_t'(new_mode); // [R1]
      end
      if (wr_mv) begin
        mv_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::PCT_FULL);
      end
      if (wr_db) begin
        pos_db_ff <= sat(wdata, valve_pkg::DB_MIN, valve_pkg::DB_MAX); // [R10]
        db_user_ff <= 1'b1;
      end else if (wr_ctrl && !db_user_ff) begin
        // Untouched dead band follows the default of the selected mode
        pos_db_ff <= new_mode ? valve_pkg::DB_RST_FEEDBACK : valve_pkg::DB_RST_ESTIMATE; // [R10]
      end
      if (wr_hyst) begin
        hyst_ff <= sat(wdata, valve_pkg::HYST_MIN, valve_pkg::HYST_MAX); // [R11]
      end
      if (wr_pvdb) begin
        pv_db_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::PV_DB_MAX); // [R12]
      end
      if (cal_ok) begin
        travel_ff <= sat(stroke_s[15:0], valve_pkg::ZERO16, valve_pkg::TRAVEL_MAX); // [R6]
        open_ff <= sat(cal_open_ff, valve_pkg::ZERO16, valve_pkg::COUNT_MAX); // [R5]
        shut_ff <= sat(pot.count, valve_pkg::ZERO16, valve_pkg::COUNT_MAX); // [R5]
        pot_rng_ff <= rng_cal; // [R5]
      end else begin
        if (wr_travel) begin
          travel_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::TRAVEL_MAX); // [R13]
        end
        if (wr_shut) begin
          shut_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::COUNT_MAX); // [R14]
        end
        if (wr_open) begin
          open_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::COUNT_MAX); // [R14]
        end
        if (wr_rng) begin
          pot_rng_ff <= sat(wdata, valve_pkg::ZERO16, valve_pkg::POT_RNG_MAX);
        end
      end
      if (cal_ok) begin
        calibrated_ff <= 1'b1;
      end
      if (cal_start) begin
        cal_err_ff <= 1'b0;
      end else if (cal_fail) begin
        cal_err_ff <= 1'b1; // [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Opening from pot and from travel-time estimate
  // ----------------------------------------------------------------
  logic [19:0] est_ms_ff;
  wire [19:0] travel_ms = 20'(travel_ff * valve_pkg::MS_PER_S);
  wire signed [16:0] pot_rel = $signed({1'b0, pot.count}) - $signed({1'b0, shut_ff});
  wire signed [16:0] span = $signed({1'b0, open_ff}) - $signed({1'b0, shut_ff});
  wire span_ok = span > 17'sd0;
  wire signed [27:0] pot_scaled = pot_rel * $signed({1'b0, valve_pkg::PCT_FULL});
  wire signed [27:0] pot_pct_raw = span_ok ? pot_scaled / span : 28'sd0;
  wire signed [15:0] mon_min = $signed(valve_pkg::MON_MIN);
  wire signed [15:0] mon_max = $signed(valve_pkg::MON_MAX);
  wire signed [15:0] pot_pct = pot_pct_raw < 28'(mon_min) ? mon_min :
                               (pot_pct_raw > 28'(mon_max) ? mon_max : pot_pct_raw[15:0]); // [R8]
  wire [29:0] est_scaled = est_ms_ff * 30'(valve_pkg::PCT_FULL);
  wire [29:0] est_pct_raw = travel_ms == 20'h0_0000 ? 30'h0000_0000 : est_scaled / travel_ms;
  wire signed [15:0] est_pct = $signed(est_pct_raw[15:0]); // [R15]
  wire mon_err_now = !calibrated_ff || !pres_ff || pot.fault || !pot.valid || !span_ok; // [R8]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      est_ms_ff <= 20'h0_0000;
    end else if (est_ms_ff > travel_ms) begin
      est_ms_ff <= travel_ms; // Travel time lowered under the estimate
    end else if (tick && drv_ff.open_drv && est_ms_ff < travel_ms) begin
      est_ms_ff <= est_ms_ff + 20'h0_0001; // [R15]
    end else if (tick && drv_ff.close_drv && est_ms_ff != 20'h0_0000) begin
      est_ms_ff <= est_ms_ff - 20'h0_0001; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Drive decision with dead bands and hysteresis
  // ----------------------------------------------------------------
  // Estimate mode never looks at the pot, so a missing pot cannot stall it
  wire signed [15:0] opening = mode_ff == valve_pkg::FEEDBACK_LOOP_MODE ? pot_pct : est_pct; // [R2]
  wire signed [16:0] dev = $signed({1'b0, mv_ff}) - 17'(opening);
  wire signed [16:0] db_s = $signed({1'b0, pos_db_ff});
  wire signed [16:0] on_s = $signed({1'b0, pos_db_ff}) + $signed({1'b0, hyst_ff}); // [R11]
  wire signed [16:0] pv_dev = $signed({1'b0, process_value}) - $signed({1'b0, set_point});
  wire [16:0] pv_abs = pv_dev < 17'sd0 ? 17'(-pv_dev) : 17'(pv_dev);
  wire pv_hold = pv_db_ff != 16'h0000 && pv_abs <= {1'b0, pv_db_ff}; // [R12]
  wire fb_blind = mode_ff == valve_pkg::FEEDBACK_LOOP_MODE && mon_err_now;
  wire open_on = dev >= on_s;
  wire open_keep = dev > db_s; // [R9]
  wire close_on = dev <= -on_s;
  wire close_keep = dev < -db_s; // [R9]
  wire run_ok = !pv_hold && !fb_blind;
  wire nxt_open = cal_ff == CAL_OPEN ||
                  (cal_ff == CAL_IDLE && run_ok && (open_on || (drv_ff.open_drv && open_keep)));
  wire nxt_close = cal_ff == CAL_CLOSE ||
                   (cal_ff == CAL_IDLE && run_ok && (close_on || (drv_ff.close_drv && close_keep)));
  wire fb_mode = mode_ff == valve_pkg::FEEDBACK_LOOP_MODE;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drv_ff <= '0;
      feat_ff <= '0;
    end else begin
      drv_ff.open_drv <= nxt_open; // [R9]
      drv_ff.close_drv <= nxt_close; // [R9]
      feat_ff.onoff_allowed <= 1'b0; // [R3]
      feat_ff.loop_break_alarm_allowed <= 1'b0; // [R3]
      feat_ff.heater_alarm_allowed <= 1'b0; // [R3]
      feat_ff.p_pd_allowed <= fb_mode; // [R3]
      feat_ff.at40_allowed <= fb_mode; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------------
  wire [valve_pkg::NUM_EVT-1:0] evt;
  assign evt[valve_pkg::EVT_CAL_DONE] = cal_ok;
  assign evt[valve_pkg::EVT_CAL_ERR] = cal_fail;
  assign evt[valve_pkg::EVT_MON_ERR] = mon_err_now && !mon_err_ff;
  wire [valve_pkg::NUM_EVT-1:0] clr = wr_clr ? wdata[valve_pkg::NUM_EVT-1:0] : '0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sts_ff <= '0;
      ena_ff <= '0;
      mon_err_ff <= 1'b0;
    end else begin
      sts_ff <= (sts_ff & ~clr) | evt;
      mon_err_ff <= mon_err_now;
      if (wr_ena) begin
        ena_ff <= wdata[valve_pkg::NUM_EVT-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire cal_busy = cal_ff != CAL_IDLE; // [R4]
  wire [15:0] rd_ctrl = {14'h0000, cal_busy, mode_ff == valve_pkg::FEEDBACK_LOOP_MODE};
  wire [15:0] rd_mon = mon_err_now ? 16'h8000 : pot_pct; // [R8]
  wire [15:0] rd_drive = {12'h000, cal_err_ff, est_pct_raw[10] , drv_ff.close_drv,
                          drv_ff.open_drv};
  logic [15:0] rd_mux;
  always_comb begin
    case (idx)
      valve_pkg::IDX_CTRL: rd_mux = rd_ctrl;
      valve_pkg::IDX_MV: rd_mux = mv_ff;
      valve_pkg::IDX_POS_DB: rd_mux = pos_db_ff;
      valve_pkg::IDX_HYST: rd_mux = hyst_ff;
      valve_pkg::IDX_PV_DB: rd_mux = pv_db_ff;
      valve_pkg::IDX_TRAVEL: rd_mux = travel_ff;
      valve_pkg::IDX_SHUT: rd_mux = shut_ff;
      valve_pkg::IDX_OPEN: rd_mux = open_ff;
      valve_pkg::IDX_POT_RNG: rd_mux = pot_rng_ff;
      valve_pkg::IDX_MONITOR: rd_mux = rd_mon;
      valve_pkg::IDX_STATUS: rd_mux = {13'h0000, sts_ff};
      valve_pkg::IDX_ENABLE: rd_mux = {13'h0000, ena_ff};
      valve_pkg::IDX_DRIVE: rd_mux = rd_drive;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= rd ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_ff;
  assign irq = |(sts_ff & ena_ff);
  assign drive = drv_ff;
  assign features = feat_ff;
endmodule

// ---- tb/valve_motor_model.sv ----
// Valve motor with feedback pot, one count a cycle between end stops
`timescale 1ns/10ps
module valve_motor_model (
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, active low
  input wire valve_pkg::drive_t drive, // Motor run commands
  input wire logic fault_inj, // Forces a pot fault
  output valve_pkg::pot_in_t pot // Pot sample
);
  logic [15:0] pos_ff;
  // End stops hold the count still so the block sees a stall
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pos_ff <= 16'h0BB8;
    else if (drive.open_drv && pos_ff < 16'h1B58) pos_ff <= pos_ff + 16'h0001;
    else if (drive.close_drv && pos_ff > 16'h03E8) pos_ff <= pos_ff - 16'h0001;
  end
  assign pot = {1'b1, fault_inj, pos_ff};
endmodule

// ---- tb/valve_position_ctrl_asserts.sv ----
// Port-level checks for the valve position drive block
`timescale 1ns/10ps
module valve_position_ctrl_asserts #(
  parameter int MS_CYCLES = 4
) (
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [7:0] addr, // Byte address
  input wire logic rd, // Read strobe
  input wire logic [15:0] rdata, // Read data
  input wire valve_pkg::drive_t drive, // Motor outputs
  input wire valve_pkg::feature_t features // Feature permits
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic [7:0] idx;
  assign idx = {2'b00, addr[7:2]};
  // ----------------------------------------------------------------
  // Drive and feature outputs
  // ----------------------------------------------------------------
  property p_one_way; !(drive.open_drv && drive.close_drv); endproperty
  a_one_way: assert property (p_one_way) else $error("open and close both on");
  property p_no_onoff;
    !(features.onoff_allowed || features.loop_break_alarm_allowed || features.heater_alarm_allowed);
  endproperty
  a_no_onoff: assert property (p_no_onoff) else $error("forbidden feature permitted");
  property p_pd_at40;
    rd && idx == valve_pkg::IDX_CTRL |=>
      features.p_pd_allowed == rdata[valve_pkg::CTRL_MODE_BIT] &&
      features.at40_allowed == rdata[valve_pkg::CTRL_MODE_BIT];
  endproperty
  a_pd_at40: assert property (p_pd_at40) else $error("pd and tune permits differ");
  // ----------------------------------------------------------------
  // Read data idle value and ranges
  // ----------------------------------------------------------------
  property p_rd_idle; !rd |=> rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_mon;
    rd && idx == valve_pkg::IDX_MONITOR |=> rdata == 16'h8000 ||
      ($signed(rdata) >= $signed(valve_pkg::MON_MIN) && $signed(rdata) <= 16'sh044C);
  endproperty
  a_mon: assert property (p_mon) else $error("opening monitor out of range");
  property p_travel; rd && idx == valve_pkg::IDX_TRAVEL |=> rdata <= valve_pkg::TRAVEL_MAX;
  endproperty
  a_travel: assert property (p_travel) else $error("travel time out of range");
  property p_db;
    rd && idx == valve_pkg::IDX_POS_DB |=> rdata inside {[valve_pkg::DB_MIN:valve_pkg::DB_MAX]};
  endproperty
  a_db: assert property (p_db) else $error("dead band out of range");
  property p_hyst;
    rd && idx == valve_pkg::IDX_HYST |=> rdata inside {[valve_pkg::HYST_MIN:valve_pkg::HYST_MAX]};
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis out of range");
endmodule
bind valve_position_ctrl valve_position_ctrl_asserts #(.MS_CYCLES(MS_CYCLES)) chk_i (
  .mclk(mclk), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata), .drive(drive),
  .features(features));

// ---- tb/valve_position_proportional_control_tb_top.sv ----
// Self-checking bench for the valve position drive block
`timescale 1ns/10ps
module valve_position_proportional_control_tb_top;
  logic mclk, nrst, wr, rd, fault_inj, irq;
  logic pres = 1'b1;
  logic [7:0] addr;
  logic [15:0] wdata, pv, sp, rdata;
  valve_pkg::pot_in_t pot;
  valve_pkg::drive_t drive;
  valve_pkg::feature_t features;
  int mismatches, comparisons, n;
  int exp_c = (500 - 20) * 4;
  int mdl[16] = '{0, 0, 20, 8, 0, 30, 0, 9999, 0, 32768, 4, 0, 0, 0, 0, 0};
  int hi[9] = '{3, 1000, 100, 200, 9999, 999, 9999, 9999, 5};
  logic [31:0] seed = 32'he732_d4d4;
  valve_position_ctrl #(.MS_CYCLES(4)) dut (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pot(pot),
    .pot_present_pin(pres), .process_value(pv), .set_point(sp), .drive(drive),
    .features(features));
  valve_motor_model motor (.mclk(mclk), .nrst(nrst), .drive(drive), .fault_inj(fault_inj),
    .pot(pot));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input int exp);
    comparisons++;
    if (got !== exp[15:0]) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp[15:0]);
    end
  endtask
  task automatic wr_reg(input int i, input int d);
    @(posedge mclk);
    addr <= 8'(i * 4);
    wdata <= d[15:0];
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    // Model saturates settings the way the block must
    if (i >= 1 && i <= 8) mdl[i] = (d > hi[i]) ? hi[i] : ((i == 2 || i == 3) && d < 1) ? 1 : d;
  endtask
  task automatic rd_chk(input int i, input int exp);
    @(posedge mclk);
    addr <= 8'(i * 4);
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic hold(input int c, input int exp);
    repeat (c) begin
      @(posedge mclk);
      #1 chk(16'(drive), exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #950_000;
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {wr, rd, fault_inj, addr, wdata, pv, sp} = '0;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) if (i != 11 && i != 13) rd_chk(i, mdl[i]);
    chk(16'(features), 0);
    $display("test reset values done");
    wr_reg(5, 1);
    wr_reg(1, 500);
    hold(2, 2);
    for (n = 0; drive.open_drv === 1'b1 && n < 8000; n++) @(posedge mclk);
    chk(16'(n > exp_c - 20 && n < exp_c + 20), 1);
    wr_reg(1, 505);
    hold(20, 0);
    wr_reg(1, 515);
    hold(3, 2);
    wr_reg(1, 1000);
    wr_reg(4, 50);
    sp <= 16'h0014;
    hold(20, 0);
    sp <= 16'h00C8;
    hold(3, 2);
    wr_reg(4, 0);
    $display("test estimate drive done");
    wr_reg(0, 1);
    rd_chk(2, 40);
    chk(16'(features), 3);
    wr_reg(0, 0);
    rd_chk(2, 20);
    wr_reg(9, 5);
    rd_chk(9, 32768);
    repeat (24) begin
      n = 1 + int'(xs() % 8);
      wr_reg(n, int'(xs() & 32'h0000_7FFF));
      rd_chk(n, mdl[n]);
    end
    $display("test settings done");
    wr_reg(1, 0);
    wr_reg(11, 7);
    wr_reg(12, 3);
    wr_reg(0, 2);
    hold(2, 2);
    rd_chk(0, 2);
    for (n = 0; irq !== 1'b1 && n < 60000; n++) @(posedge mclk);
    chk(16'(irq), 1);
    mdl[5] = 1;
    mdl[6] = 1000;
    mdl[7] = 7000;
    mdl[8] = 3;
    for (int i = 5; i <= 8; i++) rd_chk(i, mdl[i]);
    rd_chk(0, 0);
    rd_chk(10, 1);
    rd_chk(9, 0);
    wr_reg(11, 1);
    @(posedge mclk);
    #1 chk(16'(irq), 0);
    $display("test calibration done");
    fault_inj <= 1'b1;
    wr_reg(0, 2);
    for (n = 0; irq !== 1'b1 && n < 60000; n++) @(posedge mclk);
    fault_inj <= 1'b0;
    rd_chk(10, 6);
    rd_chk(6, 1000);
    $display("test calibration error done");
    wr_reg(6, 2000);
    rd_chk(9, -100);
    @(posedge mclk);
    pres <= 1'b0;
    repeat (6) @(posedge mclk);
    rd_chk(9, 32768);
    $display("test monitor limits done");
    give_verdict();
  end
endmodule
